// >>> vlo_pkg.sv
// Package with constants and carrier types for the valley-lockout switch timing.
package vlo_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ            = 10000;
  localparam int MAX_FREQ_SET_PIN_KHZ           = 110;
  localparam int MAX_FREQ_SET_PIN_CYC           = (CLK_KHZ + MAX_FREQ_SET_PIN_KHZ - 1) / MAX_FREQ_SET_PIN_KHZ;
  localparam int STEADY_TOUT_US     = 6;
  localparam int STEADY_TOUT_CYC    = STEADY_TOUT_US * CLK_KHZ / 1000;
  localparam int SOFT_TOUT_US       = 100;
  localparam int SOFT_TOUT_CYC      = SOFT_TOUT_US * CLK_KHZ / 1000;
  localparam int MAX_DEAD_US        = 32;
  localparam int MAX_DEAD_CYC       = MAX_DEAD_US * CLK_KHZ / 1000;
  localparam int MAX_PERIOD_US      = 40;
  localparam int MAX_PERIOD_CYC     = MAX_PERIOD_US * CLK_KHZ / 1000;
  localparam int QUIET_US           = 1250;
  localparam int QUIET_CYC          = QUIET_US * CLK_KHZ / 1000;
  localparam int BURST_PULSES       = 3;
  localparam int CNT_W              = 14;

  // ----------------------------------------------------------------------
  // Feedback code: millivolts divided by FB_LSB_MV, 8 bits
  // ----------------------------------------------------------------------
  localparam int FB_LSB_MV          = 10;
  localparam logic [7:0] FB_FOLD_HI = 8'h50;
  localparam logic [7:0] FB_FOLD_LO = 8'h28;
  localparam logic [7:0] FB_HYS     = 8'h3C;
  localparam logic [7:0] FB_BURST_X = 8'h64;
  localparam int FOLD_SPAN          = 40;
  localparam logic [2:0] V_FIRST    = 3'h1;
  localparam logic [2:0] V_LAST     = 3'h6;

  // Falling thresholds move valley n to n+1; index is n - 1.
  localparam logic [7:0] FALL_TH [0:4] =
    '{8'h8C, 8'h78, 8'h6E, 8'h64, 8'h5A};

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fb_code;
    logic       skip_low;
    logic       skip_high;
    logic       zcd_low;
    logic       max_freq_set_pin_high;
    logic       demag_done;
  } cmp_t;

  typedef struct packed {
    logic       pulse_end;
    logic       softstart;
    logic       max_freq_set_pin_pin_var;
  } ctl_t;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_DEAD  = 2'b01,
    ST_DRIVE = 2'b11,
    ST_QUIET = 2'b10
  } sw_state_t;

endpackage

// >>> vlo_down_timer.sv
// Down counter used for every timed interval of the switching logic.
`timescale 1ns/1ps
module vlo_down_timer #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // Status
  output logic              o_running,
  output logic              o_expire
);

  logic [W-1:0] count;
  wire          last = (count == W'(1));

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      count    <= '0;
      o_expire <= 1'b0;
    end
    else
    begin
      count    <= i_load ? i_count : (count != '0 ? count - W'(1) : count);
      o_expire <= !i_load && last;
    end
  end

  assign o_running = (count != '0);

endmodule

// >>> vlo_switch_timing.sv
// Switching-cycle timing for a quasi-resonant valley-lockout controller.
// Summary of operation
// - Optional 110 kHz maximum frequency clamp.
// - Clamp pin above 4 V disables clamp.
// - Valley counter fires at selected valley.
// - Hold valley until threshold or +600 mV.
// - Falling and rising valley thresholds per table.
// - 600 mV hysteresis on every valley comparison.
// - 6 us timeout restarted by each valley.
// - Timeout expiry counts as a valley.
// - Soft-start uses 100 us timeout.
// - Timeouts and valleys counted toward selection.
// - Sixth valley at 0.8 V enters foldback.
// - Foldback dead-time linear to 32 us.
// - Force new cycle after 40 us.
// - Forced cycle waits for demagnetization.
// - Stop below skip, resume above hysteresis.
// - Quiet burst timer limits bursts to 800 Hz.
// - Pulse in progress always finishes.
// - Skip-exit starts quiet timer and counter.
// - Burst stops only after three pulses.
// - No restart before quiet timer expires, except above 1 V.
// - Quiet timer expiry never starts a cycle.
// - Above 1 V leave burst immediately.
// - Zero-cross falling below threshold is valley.
`timescale 1ns/1ps
module vlo_switch_timing (
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  // Analog comparator decisions and stage control
  input  wire vlo_pkg::cmp_t i_cmp,
  input  wire vlo_pkg::ctl_t i_ctl,
  // Gate drive request and mode status
  output logic               o_gate_drive_out,
  output logic               o_freeze_peak,
  output logic               o_valley_lock_mode,
  output logic               o_freq_foldback_mode,
  output logic               o_burst_mode,
  output logic [2:0]         o_valley_sel
);

  // ----------------------------------------------------------------------
  // Input staging
  // ----------------------------------------------------------------------
  // Inputs are taken as synchronous, so one register stage aligns them
  // and gives a clean previous value for edge detection.
  vlo_pkg::cmp_t cmp;
  vlo_pkg::ctl_t ctl;
  logic          zcd_prev;
  logic          demag_prev;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      // Full-scale feedback keeps the selection at valley one after reset.
      cmp         <= '0;
      cmp.fb_code <= '1;
      ctl         <= '0;
      zcd_prev    <= 1'b0;
      demag_prev  <= 1'b0;
    end
    else
    begin
      cmp      <= i_cmp;
      ctl      <= i_ctl;
      zcd_prev   <= cmp.zcd_low;
      demag_prev <= cmp.demag_done;
    end
  end

  wire valley_edge = cmp.zcd_low && !zcd_prev;
  wire demag_edge  = cmp.demag_done && !demag_prev;

  // ----------------------------------------------------------------------
  // Valley selection with hysteresis
  // ----------------------------------------------------------------------
  logic [2:0] valley_sel;
  wire  [2:0] sel_idx   = valley_sel - vlo_pkg::V_FIRST;
  wire  [7:0] fall_cur  = (valley_sel == vlo_pkg::V_LAST) ? 8'h00 :
                          vlo_pkg::FALL_TH[sel_idx];
  wire  [7:0] fall_prev = (valley_sel == vlo_pkg::V_FIRST) ? 8'h00 :
                          vlo_pkg::FALL_TH[sel_idx - 3'h1];
  wire  [8:0] rise_lvl  = {1'b0, fall_prev} + {1'b0, vlo_pkg::FB_HYS};
  wire        go_deeper = (valley_sel != vlo_pkg::V_LAST) &&
                          (cmp.fb_code < fall_cur);
  wire        go_up     = (valley_sel != vlo_pkg::V_FIRST) &&
                          ({1'b0, cmp.fb_code} > rise_lvl);
  wire  [2:0] next_valley_sel = go_deeper ? valley_sel + 3'h1 :
                                go_up ? valley_sel - 3'h1 : valley_sel;

  // ----------------------------------------------------------------------
  // Foldback and burst decisions
  // ----------------------------------------------------------------------
  wire fold_now = (valley_sel == vlo_pkg::V_LAST) &&
                  (cmp.fb_code <= vlo_pkg::FB_FOLD_HI);
  wire [7:0] fb_clip = (cmp.fb_code < vlo_pkg::FB_FOLD_LO) ?
                       vlo_pkg::FB_FOLD_LO : cmp.fb_code;
  wire [7:0] fold_depth = fold_now ? vlo_pkg::FB_FOLD_HI - fb_clip : 8'h00;
  // Linear from zero at the upper limit to the full dead-time at the lower.
  wire [vlo_pkg::CNT_W-1:0] dead_cyc = vlo_pkg::CNT_W'(
       (32'(fold_depth) * vlo_pkg::MAX_DEAD_CYC) / vlo_pkg::FOLD_SPAN);
  wire burst_exit = (cmp.fb_code > vlo_pkg::FB_BURST_X);

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  vlo_pkg::sw_state_t state;
  vlo_pkg::sw_state_t next_state;
  logic [2:0] valley_cnt;
  logic [1:0] burst_pulses;
  logic       burst;
  logic       in_burst_run;

  wire  drive_start;
  wire  tout_run;
  wire  tout_exp;
  wire  max_freq_set_pin_run;
  wire  period_run;
  wire  dead_run;
  wire  dead_exp;
  wire  quiet_run;

  wire [vlo_pkg::CNT_W-1:0] tout_len = ctl.softstart ?
       vlo_pkg::CNT_W'(vlo_pkg::SOFT_TOUT_CYC) :
       vlo_pkg::CNT_W'(vlo_pkg::STEADY_TOUT_CYC);

  // A drive start clears the timeout; it runs again only from the next
  // demagnetization or valley, so it never counts a valley too early.
  wire tout_load = drive_start || demag_edge || valley_edge ||
                   (tout_exp && state == vlo_pkg::ST_WAIT);
  wire [vlo_pkg::CNT_W-1:0] tout_count = drive_start ? '0 : tout_len;

  vlo_down_timer #(.W(vlo_pkg::CNT_W)) u_tout (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_load    (tout_load),
    .i_count   (tout_count),
    .o_running (tout_run),
    .o_expire  (tout_exp)
  );

  vlo_down_timer #(.W(vlo_pkg::CNT_W)) u_max_freq_set_pin (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_load    (drive_start),
    .i_count   (vlo_pkg::CNT_W'(vlo_pkg::MAX_FREQ_SET_PIN_CYC)),
    .o_running (max_freq_set_pin_run),
    .o_expire  ()
  );

  vlo_down_timer #(.W(vlo_pkg::CNT_W)) u_period (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_load    (drive_start),
    .i_count   (vlo_pkg::CNT_W'(vlo_pkg::MAX_PERIOD_CYC)),
    .o_running (period_run),
    .o_expire  ()
  );

  wire dead_load = (state == vlo_pkg::ST_WAIT) && (next_state ==
                   vlo_pkg::ST_DEAD);

  vlo_down_timer #(.W(vlo_pkg::CNT_W)) u_dead (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_load    (dead_load),
    .i_count   (dead_cyc),
    .o_running (dead_run),
    .o_expire  (dead_exp)
  );

  // The quiet timer starts with each burst, so it spaces burst starts.
  wire quiet_load = (state == vlo_pkg::ST_QUIET) &&
                    (next_state == vlo_pkg::ST_WAIT);

  vlo_down_timer #(.W(vlo_pkg::CNT_W)) u_quiet (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_load    (quiet_load),
    .i_count   (vlo_pkg::CNT_W'(vlo_pkg::QUIET_CYC)),
    .o_running (quiet_run),
    .o_expire  ()
  );

  // ----------------------------------------------------------------------
  // Cycle decisions
  // ----------------------------------------------------------------------
  wire max_freq_set_pin_block  = ctl.max_freq_set_pin_pin_var ? (max_freq_set_pin_run && !cmp.max_freq_set_pin_high) :
                     max_freq_set_pin_run;
  wire valley_evt  = valley_edge || tout_exp;
  wire valley_hit  = valley_evt && (valley_cnt + 3'h1 >= valley_sel);
  wire force_cycle = !period_run && cmp.demag_done;
  // Skip allows a burst only above the upper skip level and past the
  // quiet timer; the timer alone never restarts switching.
  wire skip_block_n = cmp.skip_high && !quiet_run;
  wire may_fire    = !max_freq_set_pin_block && (!burst || in_burst_run || skip_block_n);
  wire stop_req    = cmp.skip_low &&
                     (!burst || burst_pulses == 2'(vlo_pkg::BURST_PULSES));

  always_comb
  begin
    next_state = state;
    unique case (state)
      vlo_pkg::ST_WAIT:
        if (stop_req)
          next_state = vlo_pkg::ST_QUIET;
        else if ((valley_hit || force_cycle) && may_fire)
          next_state = fold_now && valley_hit && dead_cyc != '0 ?
                       vlo_pkg::ST_DEAD : vlo_pkg::ST_DRIVE;
      vlo_pkg::ST_DEAD:
        if (dead_exp || !dead_run || force_cycle)
          next_state = vlo_pkg::ST_DRIVE;
      vlo_pkg::ST_DRIVE:
        if (ctl.pulse_end)
          next_state = stop_req ? vlo_pkg::ST_QUIET : vlo_pkg::ST_WAIT;
      vlo_pkg::ST_QUIET:
        if (burst_exit || skip_block_n)
          next_state = vlo_pkg::ST_WAIT;
    endcase
  end

  assign drive_start = (state != vlo_pkg::ST_DRIVE) &&
                       (next_state == vlo_pkg::ST_DRIVE);

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      state        <= vlo_pkg::ST_WAIT;
      valley_sel   <= vlo_pkg::V_FIRST;
      valley_cnt   <= 3'h0;
      burst        <= 1'b0;
      in_burst_run <= 1'b0;
      burst_pulses <= 2'h0;
    end
    else
    begin
      state      <= next_state;
      valley_sel <= next_valley_sel;
      if (drive_start)
        valley_cnt <= 3'h0;
      else if (valley_evt && valley_cnt != vlo_pkg::V_LAST)
        valley_cnt <= valley_cnt + 3'h1;
      if (burst_exit)
        burst <= 1'b0;
      else if (next_state == vlo_pkg::ST_QUIET)
        burst <= 1'b1;
      if (next_state == vlo_pkg::ST_QUIET)
        in_burst_run <= 1'b0;
      else if (state == vlo_pkg::ST_QUIET)
        in_burst_run <= 1'b1;
      if (state == vlo_pkg::ST_QUIET)
        burst_pulses <= 2'h0;
      else if (drive_start && burst_pulses != 2'(vlo_pkg::BURST_PULSES))
        burst_pulses <= burst_pulses + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_gate_drive_out     <= 1'b0;
      o_freeze_peak        <= 1'b0;
      o_valley_lock_mode   <= 1'b0;
      o_freq_foldback_mode <= 1'b0;
      o_burst_mode         <= 1'b0;
      o_valley_sel         <= vlo_pkg::V_FIRST;
    end
    else
    begin
      o_gate_drive_out     <= (next_state == vlo_pkg::ST_DRIVE);
      o_freeze_peak        <= fold_now;
      o_valley_lock_mode   <= !fold_now && !burst;
      o_freq_foldback_mode <= fold_now;
      o_burst_mode         <= burst;
      o_valley_sel         <= valley_sel;
    end
  end

endmodule

// >>> vlo_switch_timing_monitor.sv
// Concurrent checks on the ports of the switch timing block.
`timescale 1ns/1ps
module vlo_switch_timing_monitor (
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  // Watched ports
  input  wire vlo_pkg::cmp_t i_cmp,
  input  wire vlo_pkg::ctl_t i_ctl,
  input  wire logic          o_gate_drive_out,
  input  wire logic          o_freeze_peak,
  input  wire logic          o_valley_lock_mode,
  input  wire logic          o_freq_foldback_mode,
  input  wire logic          o_burst_mode,
  input  wire logic [2:0]    o_valley_sel
);
  // ----------------------------------------------------------------------
  // Cycles since the last drive start
  // ----------------------------------------------------------------------
  logic [7:0] since;
  logic       gate_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk_sys)
  begin
    gate_q <= o_gate_drive_out;
    if (!i_rstn)
      since <= 8'hFF;
    else if (o_gate_drive_out && !gate_q)
      since <= 8'h01;
    else if (since != 8'hFF)
      since <= since + 8'h01;
  end
  a_clamp_spacing: assert property ($rose(o_gate_drive_out) &&
    !(i_ctl.max_freq_set_pin_pin_var && i_cmp.max_freq_set_pin_high) |-> since >= 8'h5A)
    else $error("drive start inside the clamp period");
  a_pulse_whole: assert property ($fell(o_gate_drive_out) |->
    $past(i_ctl.pulse_end, 2)) else $error("drive pulse cut short");
  a_valley_range: assert property (o_valley_sel >= 3'h1 &&
    o_valley_sel <= 3'h6) else $error("valley selection out of range");
  a_freeze_fold: assert property (o_freeze_peak ==
    o_freq_foldback_mode) else $error("peak freeze differs from foldback");
  a_fold_sixth: assert property ($rose(o_freq_foldback_mode) |->
    o_valley_sel == 3'h6) else $error("foldback entered before valley six");
  a_lock_excl: assert property (o_valley_lock_mode |->
    !o_burst_mode && !o_freq_foldback_mode)
    else $error("lockout mode overlaps another mode");
  a_reset_outs: assert property (disable iff (1'b0) !i_rstn |=>
    !o_gate_drive_out && o_valley_sel == 3'h1 && !o_burst_mode)
    else $error("outputs not cleared by reset");
  a_first_fire: assert property ($rose(i_cmp.zcd_low) &&
    o_valley_sel == 3'h1 && o_valley_lock_mode && !o_gate_drive_out &&
    since >= 8'h64 && i_cmp.demag_done && !i_cmp.skip_low
    |-> ##[1:3] o_gate_drive_out) else $error("first valley did not fire");
  c_burst: cover property ($rose(o_burst_mode));
  c_fold: cover property ($rose(o_freq_foldback_mode));
  c_sixth: cover property (o_valley_sel == 3'h6 && o_gate_drive_out);
endmodule

// >>> vlo_stage_model.sv
// Behavioural flyback stage answering the gate drive request.
`timescale 1ns/1ps
module vlo_stage_model (
  // Clock
  input  wire logic i_clk_sys,
  // Gate request and ringing control
  input  wire logic i_gate,
  input  wire logic i_ring_on,
  // Stage answers
  output logic      o_pulse_end,
  output logic      o_demag_done,
  output logic      o_zcd_low
);
  // Ringing keeps a fixed 16-cycle period; a real stage would fade out.
  logic [9:0] ph = 10'h000;
  logic [3:0] rc = 4'h0;
  logic       gate_q = 1'b0;
  initial {o_pulse_end, o_demag_done, o_zcd_low} = 3'b000;
  always @(posedge i_clk_sys)
  begin
    gate_q <= i_gate;
    rc <= rc + 4'h1;
    ph <= (i_gate != gate_q) ? 10'h000 : (ph == 10'h3FF ? ph : ph + 10'h001);
    o_pulse_end <= i_gate && ph >= 10'h013;
    o_demag_done <= !i_gate && ph >= 10'h01E;
    o_zcd_low <= i_ring_on && o_demag_done && rc[3:2] == 2'b11;
  end
endmodule

// >>> valley_lockout_switch_timing_test.sv
// Self-checking bench for the valley-lockout switch timing block.
`timescale 1ns/1ps
module valley_lockout_switch_timing_test;
  logic clk_sys = 1'b0, rstn = 1'b0, skip_low = 1'b0, skip_high = 1'b1;
  logic max_freq_set_pin_high = 1'b0, softstart = 1'b0, pin_var = 1'b0, ring_on = 1'b1;
  logic [7:0] fb = 8'hC8;
  logic pe, dm, zl, gate, freeze, lock, fold, burst;
  logic [2:0] sel;
  int fails = 0, n_tests = 0;
  vlo_pkg::cmp_t cmp;
  vlo_pkg::ctl_t ctl;
  assign cmp = '{fb, skip_low, skip_high, zl, max_freq_set_pin_high, dm};
  assign ctl = '{pe, softstart, pin_var};
  always #50 clk_sys = ~clk_sys;
  vlo_switch_timing vlo_switch_timing_inst (.i_clk_sys(clk_sys),
    .i_rstn(rstn), .i_cmp(cmp), .i_ctl(ctl), .o_gate_drive_out(gate),
    .o_freeze_peak(freeze), .o_valley_lock_mode(lock),
    .o_freq_foldback_mode(fold), .o_burst_mode(burst), .o_valley_sel(sel));
  vlo_stage_model vlo_stage_model_inst (.i_clk_sys(clk_sys), .i_gate(gate),
    .i_ring_on(ring_on), .o_pulse_end(pe), .o_demag_done(dm), .o_zcd_low(zl));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic count_rises(input int cyc, output int k);
    logic p;
    k = 0;
    p = gate;
    repeat (cyc)
    begin
      @(negedge clk_sys);
      if (gate === 1'b1 && p !== 1'b1)
        k++;
      p = gate;
    end
  endtask
  // Cycles until the next drive start, giving up after 20000.
  task automatic wait_rise(output int n);
    logic p;
    logic r;
    n = 0;
    p = gate;
    do
    begin
      @(negedge clk_sys);
      n++;
      r = (gate === 1'b1 && p !== 1'b1);
      p = gate;
    end while (!r && n < 20000);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_valley_one;
    int n;
    count_rises(300, n);
    wait_rise(n);
    wait_rise(n);
    check(n >= vlo_pkg::MAX_FREQ_SET_PIN_CYC - 1 && n < 2 * vlo_pkg::MAX_FREQ_SET_PIN_CYC, 1);
    check(sel, 3'h1);
    check(lock, 1'b1);
    pin_var = 1'b1;
    max_freq_set_pin_high = 1'b1;
    count_rises(300, n);
    wait_rise(n);
    wait_rise(n);
    check(n < vlo_pkg::MAX_FREQ_SET_PIN_CYC - 5, 1);
  endtask
  task automatic t_timeout;
    int n;
    ring_on = 1'b0;
    wait_rise(n);
    // The stage still shows the last demagnetization just after a start.
    while (dm === 1'b1)
      @(negedge clk_sys);
    while (dm !== 1'b1)
      @(negedge clk_sys);
    wait_rise(n);
    check(n >= vlo_pkg::STEADY_TOUT_CYC - 2, 1);
    check(n <= vlo_pkg::STEADY_TOUT_CYC + 6, 1);
    softstart = 1'b1;
    wait_rise(n);
    wait_rise(n);
    check(n >= vlo_pkg::MAX_PERIOD_CYC - 3, 1);
    check(n <= vlo_pkg::MAX_PERIOD_CYC + 5, 1);
    softstart = 1'b0;
    ring_on = 1'b1;
  endtask
  task automatic t_lockout;
    logic [7:0] fbv [0:8];
    logic [2:0] sv [0:8];
    int n;
    fbv = '{8'h96, 8'h82, 8'h73, 8'h69, 8'h5F, 8'h55, 8'h4B, 8'h91, 8'h97};
    sv = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6, 3'h5};
    for (int i = 0; i < 9; i++)
    begin
      fb = fbv[i];
      count_rises(500, n);
      check(sel, sv[i]);
      check(fold, i == 6);
    end
    fb = 8'h55;
    count_rises(500, n);
    fb = 8'h3C;
    count_rises(800, n);
    wait_rise(n);
    wait_rise(n);
    check(n > 250 && n < vlo_pkg::MAX_PERIOD_CYC, 1);
    fb = 8'h28;
    count_rises(800, n);
    wait_rise(n);
    wait_rise(n);
    check(n > 300 && n <= vlo_pkg::MAX_PERIOD_CYC + 5, 1);
  endtask
  task automatic t_burst;
    int n;
    int k;
    int m;
    fb = 8'h32;
    skip_low = 1'b1;
    skip_high = 1'b0;
    count_rises(1000, n);
    check(burst, 1'b1);
    count_rises(1000, n);
    check(n, 0);
    {skip_low, skip_high} = 2'b01;
    wait_rise(m);
    check(m < 3000, 1);
    {skip_low, skip_high} = 2'b10;
    count_rises(3000, k);
    check(k, 2);
    {skip_low, skip_high} = 2'b01;
    wait_rise(n);
    // The quiet timer runs from the previous burst start, m + 3000 ago.
    check(m + 3000 + n >= vlo_pkg::QUIET_CYC, 1);
    check(m + 3000 + n <= vlo_pkg::QUIET_CYC + 20, 1);
    {skip_low, skip_high} = 2'b10;
    count_rises(3000, k);
    check(k, 2);
    fb = 8'h6E;
    {skip_low, skip_high} = 2'b01;
    wait_rise(n);
    check(n < 100, 1);
    count_rises(10, k);
    check(burst, 1'b0);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    t_valley_one();
    t_timeout();
    t_lockout();
    t_burst();
    end_of_test();
  end
  initial
  begin
    #(90000 * 100);
    fails++;
    end_of_test();
  end
endmodule
bind vlo_switch_timing vlo_switch_timing_monitor vlo_switch_timing_monitor_inst
  (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cmp(i_cmp), .i_ctl(i_ctl),
  .o_gate_drive_out(o_gate_drive_out), .o_freeze_peak(o_freeze_peak),
  .o_valley_lock_mode(o_valley_lock_mode), .o_burst_mode(o_burst_mode),
  .o_freq_foldback_mode(o_freq_foldback_mode), .o_valley_sel(o_valley_sel));
